// *** common/sods_pkg.sv ***
// shared constants for the speaker output diagnostic sequencer
// assumes a single 25 MHz clock; counts derive from times below
`default_nettype none
package sods_pkg;
    // clock rate and documented times
    localparam int CLK_HZ = 25_000_000;
    localparam int PULSE_MS = 100;      // turn-on acquisition time
    localparam int DIAG_MS = 100;       // permanent diagnostic cycle
    localparam int CHECK_MS = 1;        // overload recheck interval
    // derived cycle counts (exact at 25 MHz)
    localparam int PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
    localparam int DIAG_CYC = CLK_HZ / 1000 * DIAG_MS;
    localparam int CHECK_CYC = CLK_HZ / 1000 * CHECK_MS;
    // ac test: least pulses that prove a tweeter present
    localparam logic [1:0] AC_MIN_PULSES = 2'h3;
    // fault code layout, one nibble per channel
    localparam int FLT_W = 4;
    localparam int FLT_GND = 3;
    localparam int FLT_VS = 2;
    localparam int FLT_SHORT = 1;
    localparam int FLT_OPEN = 0;
    localparam logic [3:0] FLT_NONE = 4'h0;
    // turn-on sequence states, gray along idle-pulse-bias
    typedef enum logic [1:0] {
        TO_IDLE = 2'h0,
        TO_PULSE = 2'h1,
        TO_BIAS = 2'h3
    } sods_ton_t;
    // per-channel permanent states, gray around the loop
    typedef enum logic [1:0] {
        P_ACTIVE = 2'h0,
        P_WAIT = 2'h1,
        P_DIAG = 2'h3,
        P_RESTART = 2'h2
    } sods_perm_t;
endpackage : sods_pkg
`default_nettype wire

// *** core/sods_sequencer.sv ***
// diagnostic sequencing and result latching for a four-channel amplifier
// assumes host command/read strobes come from i2c logic on clk;
// analog comparator flags are asynchronous and get synchronised here
//
// What this block does
// - turn-on result held until next requested pulse
// - combined standby-out plus diag: pulse first if armed by reset or a read, outputs off
// - after bias, permanent diagnostics; keep turn-on result
// - latch output status at pulse plateau end
// - low gain plus line-driver selects high-impedance bands
// - restart mode: faulted channel off, recheck each 1ms
// - diagnostic mode host-enabled, triggered by overload
// - overload gone at 1ms check: channel resumes
// - overload still present: run 100ms diagnostic cycle
// - after cycle: channel to restart, latch fault
// - no further cycle until host reads
// - offset flagged only if high whole window
// - offset window from last read or enable bit
// - overload disables offset and ac tests
// - ac test enabled by its enable bit
// - threshold bit selects ac detection level
// - fewer than three pulses means open tweeter
// - ground and supply shorts reported together in one nibble
// - ground or supply short beats load faults
// - short with open speaker is double fault
// - permanent diagnostics never report open load
// - read re-arms cycles, returns previous results
`default_nettype none
module sods_sequencer #(
    parameter int NCH = 4,                             // channel count
    parameter int PULSE_CYC = sods_pkg::PULSE_CYC,     // turn-on pulse length
    parameter int DIAG_CYC = sods_pkg::DIAG_CYC,       // diagnostic cycle length
    parameter int CHECK_CYC = sods_pkg::CHECK_CYC      // recheck interval
) (
    input wire logic clk,                              // 25 MHz clock
    input wire logic reset,                            // sync reset, active high
    input wire logic cmdWrite,                         // instruction bytes written
    input wire logic standbyOut,                       // leave standby
    input wire logic diagEnable,                       // diagnostic mode enable
    input wire logic offset_test_enable_bit,           // first instruction byte
    input wire logic ac_test_enable_bit,               // second instruction byte
    input wire logic ac_threshold_select_bit,          // second instruction byte
    input wire logic voltage_gain_setting,             // 1 = 16 dB low gain
    input wire logic lineDriverDiag,                   // line-driver diagnostic
    input wire logic hostRead,                         // one-cycle read strobe
    input wire logic [NCH-1:0] shortGndIn,             // async comparator
    input wire logic [NCH-1:0] shortVsIn,              // async comparator
    input wire logic [NCH-1:0] loadShortIn,            // async comparator
    input wire logic [NCH-1:0] openLoadIn,             // async comparator
    input wire logic [NCH-1:0] overloadIn,             // async protection flag
    input wire logic [NCH-1:0] offsetHighIn,           // async offset > 2 V
    input wire logic [NCH-1:0] acPulseIn,              // async current > level
    output logic [NCH*4-1:0] faultRpt_r,               // fault nibbles per channel
    output logic [NCH-1:0] offsetRpt_r,                // offset flags
    output logic [NCH-1:0] tweeterOpenRpt_r,           // open tweeter flags
    output logic [NCH-1:0] stageOn_r,                  // channel power stage on
    output logic outputsHighZ_r,                       // outputs high impedance
    output logic highZBands_r,                         // line-driver load bands
    output logic acThrLow_r                            // low ac current level
);
    localparam int CW = $clog2(PULSE_CYC + DIAG_CYC + CHECK_CYC + 1);

    // priority encode: supply/ground shorts first, open only when allowed
    function automatic logic [3:0] prioFault(input logic g, input logic v,
        input logic s, input logic o, input logic allowOpen);
        logic [3:0] f;
        f = sods_pkg::FLT_NONE;
        if (g || v)
        begin
            f[sods_pkg::FLT_GND] = g;
            f[sods_pkg::FLT_VS] = v;
        end
        else if (s)
            f[sods_pkg::FLT_SHORT] = 1'b1;
        else if (o && allowOpen)
            f[sods_pkg::FLT_OPEN] = 1'b1;
        return f;
    endfunction : prioFault

    // two-flop synchronisers; first stage read only by second
    logic [NCH*7-1:0] syncA_r, syncB_r;
    always_ff @(posedge clk)
    begin
        syncA_r <= {shortGndIn, shortVsIn, loadShortIn, openLoadIn,
                    overloadIn, offsetHighIn, acPulseIn};
        syncB_r <= syncA_r;
    end
    logic [NCH-1:0] gnd, vs, lsh, opn, ovl, offH, acP;
    assign {gnd, vs, lsh, opn, ovl, offH, acP} = syncB_r;

    // turn-on sequence and global config state
    sods_pkg::sods_ton_t toState_r, toState_nxt;
    logic [CW-1:0] toCnt_r, toCnt_nxt;
    logic toArmed_r, toArmed_nxt;                      // next pulse allowed
    logic diagMode_r, diagMode_nxt;                    // diagnostic mode on
    logic highZ_nxt, bands_nxt, acThr_nxt;
    logic pulseEnd;
    assign pulseEnd = (toState_r == sods_pkg::TO_PULSE) && (toCnt_r == CW'(PULSE_CYC - 1));

    // turn-on next-state logic
    always_comb
    begin
        toState_nxt = toState_r;
        toCnt_nxt = toCnt_r;
        toArmed_nxt = toArmed_r;
        diagMode_nxt = diagMode_r;
        bands_nxt = highZBands_r;
        acThr_nxt = acThrLow_r;
        if (cmdWrite)
        begin
            diagMode_nxt = diagEnable;
            bands_nxt = voltage_gain_setting && lineDriverDiag;
            acThr_nxt = ac_threshold_select_bit;
        end
        unique case (toState_r)
            sods_pkg::TO_IDLE:
            begin
                toCnt_nxt = '0;
                if (cmdWrite && standbyOut)
                begin
                    if (diagEnable && toArmed_r)
                        toState_nxt = sods_pkg::TO_PULSE;
                    else
                        toState_nxt = sods_pkg::TO_BIAS;
                end
            end
            sods_pkg::TO_PULSE:
            begin
                toCnt_nxt = toCnt_r + CW'(1);
                if (pulseEnd)
                begin
                    toState_nxt = sods_pkg::TO_BIAS;
                    toArmed_nxt = 1'b0;
                end
            end
            sods_pkg::TO_BIAS:
            begin
                // back to standby on command
                if (cmdWrite && !standbyOut)
                    toState_nxt = sods_pkg::TO_IDLE;
            end
            // unused code: fall back to standby
            default:
                toState_nxt = sods_pkg::TO_IDLE;
        endcase
        // read re-arms; set wins over the pulse-end clear
        if (hostRead)
            toArmed_nxt = 1'b1;
        highZ_nxt = (toState_nxt != sods_pkg::TO_BIAS);
    end

    // turn-on registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            toState_r <= sods_pkg::TO_IDLE;
            toCnt_r <= '0;
            toArmed_r <= 1'b1;
            diagMode_r <= 1'b0;
            outputsHighZ_r <= 1'b1;
            highZBands_r <= 1'b0;
            acThrLow_r <= 1'b0;
        end
        else
        begin
            toState_r <= toState_nxt;
            toCnt_r <= toCnt_nxt;
            toArmed_r <= toArmed_nxt;
            diagMode_r <= diagMode_nxt;
            outputsHighZ_r <= highZ_nxt;
            highZBands_r <= bands_nxt;
            acThrLow_r <= acThr_nxt;
        end
    end

    // per-channel permanent diagnostics, offset and ac tests
    sods_pkg::sods_perm_t pst_r [NCH];
    logic [NCH-1:0] permArmed_r, offOk_r, acRun_r;
    logic [NCH*4-1:0] toRes_r, permRes_r;
    logic [NCH-1:0] permValid_r;
    genvar c;
    generate
        for (c = 0; c < NCH; c++)
        begin : g_ch
            sods_pkg::sods_perm_t pst_nxt;
            logic [CW-1:0] cnt_r, cnt_nxt;
            logic [1:0] acCnt_r, acCnt_nxt;
            logic acPrev_r, armed_nxt, offOk_nxt, acRun_nxt, valid_nxt, on_nxt;
            logic [3:0] toRes_nxt, permRes_nxt, rpt_nxt;
            logic offRpt_nxt, twRpt_nxt, cntEnd;
            logic [3:0] now;
            // short plus open reports as short (double fault)
            assign now = prioFault(gnd[c], vs[c], lsh[c], opn[c], 1'b1);
            assign cntEnd = (pst_r[c] == sods_pkg::P_DIAG) ? (cnt_r == CW'(DIAG_CYC - 1))
                                                           : (cnt_r == CW'(CHECK_CYC - 1));
            always_comb
            begin
                pst_nxt = pst_r[c];
                cnt_nxt = cnt_r + CW'(1);
                armed_nxt = permArmed_r[c];
                toRes_nxt = toRes_r[c*4 +: 4];
                permRes_nxt = permRes_r[c*4 +: 4];
                valid_nxt = permValid_r[c];
                offOk_nxt = offOk_r[c] && offH[c];
                acRun_nxt = acRun_r[c];
                acCnt_nxt = acCnt_r;
                rpt_nxt = faultRpt_r[c*4 +: 4];
                offRpt_nxt = offsetRpt_r[c];
                twRpt_nxt = tweeterOpenRpt_r[c];
                if (pulseEnd)
                begin
                    toRes_nxt = now;
                    valid_nxt = 1'b0;
                end
                unique case (pst_r[c])
                    sods_pkg::P_ACTIVE:
                    begin
                        cnt_nxt = '0;
                        if (toState_r == sods_pkg::TO_BIAS && ovl[c])
                            pst_nxt = diagMode_r ? sods_pkg::P_WAIT : sods_pkg::P_RESTART;
                    end
                    sods_pkg::P_WAIT:
                    begin
                        if (cntEnd)
                        begin
                            cnt_nxt = '0;
                            if (!ovl[c])
                                pst_nxt = sods_pkg::P_ACTIVE;
                            else
                                pst_nxt = permArmed_r[c] ? sods_pkg::P_DIAG
                                                         : sods_pkg::P_RESTART;
                        end
                    end
                    sods_pkg::P_DIAG:
                    begin
                        if (cntEnd)
                        begin
                            cnt_nxt = '0;
                            permRes_nxt = prioFault(gnd[c], vs[c], lsh[c], opn[c], 1'b0);
                            valid_nxt = 1'b1;
                            armed_nxt = 1'b0;
                            pst_nxt = sods_pkg::P_RESTART;
                        end
                    end
                    sods_pkg::P_RESTART:
                    begin
                        if (cntEnd)
                        begin
                            cnt_nxt = '0;
                            if (!ovl[c])
                                pst_nxt = sods_pkg::P_ACTIVE;
                        end
                    end
                endcase
                if (toState_r != sods_pkg::TO_BIAS)
                    pst_nxt = sods_pkg::P_ACTIVE;
                // count rising pulses, saturate at three
                if (acRun_r[c] && acP[c] && !acPrev_r && acCnt_r != sods_pkg::AC_MIN_PULSES)
                    acCnt_nxt = acCnt_r + 2'h1;
                if (cmdWrite && offset_test_enable_bit)
                    offOk_nxt = 1'b1;
                if (cmdWrite && ac_test_enable_bit)
                begin
                    acRun_nxt = 1'b1;
                    acCnt_nxt = 2'h0;
                end
                // read returns previous cycle, then re-arms
                if (hostRead)
                begin
                    rpt_nxt = permValid_r[c] ? permRes_r[c*4 +: 4] : toRes_r[c*4 +: 4];
                    offRpt_nxt = offOk_r[c];
                    twRpt_nxt = acRun_r[c] && (acCnt_r != sods_pkg::AC_MIN_PULSES);
                    offOk_nxt = 1'b1;
                    acCnt_nxt = 2'h0;
                    armed_nxt = 1'b1;
                end
                // overload kills offset and ac tests
                if (ovl[c])
                begin
                    offOk_nxt = 1'b0;
                    acRun_nxt = 1'b0;
                end
                on_nxt = (toState_r == sods_pkg::TO_BIAS) && (pst_nxt == sods_pkg::P_ACTIVE);
            end
            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    pst_r[c] <= sods_pkg::P_ACTIVE;
                    cnt_r <= '0;
                    acCnt_r <= 2'h0;
                    acPrev_r <= 1'b0;
                    permArmed_r[c] <= 1'b1;
                    toRes_r[c*4 +: 4] <= sods_pkg::FLT_NONE;
                    permRes_r[c*4 +: 4] <= sods_pkg::FLT_NONE;
                    permValid_r[c] <= 1'b0;
                    offOk_r[c] <= 1'b0;
                    acRun_r[c] <= 1'b0;
                    faultRpt_r[c*4 +: 4] <= sods_pkg::FLT_NONE;
                    offsetRpt_r[c] <= 1'b0;
                    tweeterOpenRpt_r[c] <= 1'b0;
                    stageOn_r[c] <= 1'b0;
                end
                else
                begin
                    pst_r[c] <= pst_nxt;
                    cnt_r <= cnt_nxt;
                    acCnt_r <= acCnt_nxt;
                    acPrev_r <= acP[c];
                    permArmed_r[c] <= armed_nxt;
                    toRes_r[c*4 +: 4] <= toRes_nxt;
                    permRes_r[c*4 +: 4] <= permRes_nxt;
                    permValid_r[c] <= valid_nxt;
                    offOk_r[c] <= offOk_nxt;
                    acRun_r[c] <= acRun_nxt;
                    faultRpt_r[c*4 +: 4] <= rpt_nxt;
                    offsetRpt_r[c] <= offRpt_nxt;
                    tweeterOpenRpt_r[c] <= twRpt_nxt;
                    stageOn_r[c] <= on_nxt;
                end
            end
        end
    endgenerate

    // checks on the global sequence, on channel 0 and on channel CK_CH; needs NCH above CK_CH
    localparam int CK_CH = 2;                          // channel the checks watch
    a_result_held: assert property (@(posedge clk) disable iff (reset)
        toState_r == sods_pkg::TO_BIAS |=> $stable(toRes_r)) else $error("turn-on result moved");
    a_pulse_first: assert property (@(posedge clk) disable iff (reset)
        (toState_r == sods_pkg::TO_IDLE && cmdWrite && standbyOut && diagEnable && toArmed_r)
        |=> toState_r == sods_pkg::TO_PULSE ##1 (outputsHighZ_r && stageOn_r == '0))
        else $error("pulse did not run first");
    a_read_rearm: assert property (@(posedge clk) disable iff (reset)
        hostRead |=> toArmed_r && permArmed_r[CK_CH]) else $error("read did not re-arm");
    a_diag_armed: assert property (@(posedge clk) disable iff (reset)
        $rose(pst_r[CK_CH] == sods_pkg::P_DIAG) |-> $past(permArmed_r[CK_CH]))
        else $error("diagnostic cycle without re-arm");
    a_restart_off: assert property (@(posedge clk) disable iff (reset)
        pst_r[CK_CH] == sods_pkg::P_RESTART ##1 pst_r[CK_CH] == sods_pkg::P_RESTART
        |-> !stageOn_r[CK_CH])
        else $error("restarting channel left on");
    a_perm_noopen: assert property (@(posedge clk) disable iff (reset)
        permValid_r[CK_CH] |-> !permRes_r[CK_CH*4 + sods_pkg::FLT_OPEN])
        else $error("open load in permanent");
    a_offset_clear: assert property (@(posedge clk) disable iff (reset)
        ovl[CK_CH] && !hostRead |=> !offOk_r[CK_CH] && !acRun_r[CK_CH])
        else $error("tests not disabled");
    a_band_select: assert property (@(posedge clk) disable iff (reset)
        cmdWrite |=> highZBands_r == $past(voltage_gain_setting && lineDriverDiag))
        else $error("load band select wrong");
    a_ac_level: assert property (@(posedge clk) disable iff (reset)
        cmdWrite |=> acThrLow_r == $past(ac_threshold_select_bit)) else $error("ac level wrong");
    a_gnd_priority: assert property (@(posedge clk) disable iff (reset)
        pulseEnd && gnd[0] |=> toRes_r[sods_pkg::FLT_GND] && !toRes_r[sods_pkg::FLT_SHORT])
        else $error("ground short lost priority");
endmodule : sods_sequencer
`default_nettype wire

// *** verification/sods_host_model.sv ***
// host-side partner: writes instruction settings and reads diagnostics
// assumes clk is the sequencer clock; drives just after each rising edge
`default_nettype none
module sods_host_model (
    input wire logic clk,                        // sequencer clock
    output logic cmdWrite,                       // instruction write strobe
    output logic standbyOut,                     // leave standby
    output logic diagEnable,                     // diagnostic mode enable
    output logic offset_test_enable_bit,         // offset window start
    output logic ac_test_enable_bit,             // ac test start
    output logic ac_threshold_select_bit,        // low ac current level
    output logic voltage_gain_setting,           // 16 dB low gain
    output logic lineDriverDiag,                 // line-driver diagnostic
    output logic hostRead                        // one-cycle read strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle at time zero; line-driver set-up stands until set_levels changes it
    initial
    begin
        cmdWrite = 1'b0;
        hostRead = 1'b0;
        {standbyOut, diagEnable, offset_test_enable_bit, ac_test_enable_bit} = 4'h0;
        {ac_threshold_select_bit, voltage_gain_setting, lineDriverDiag} = 3'h7;
    end
    // one write strobe; the mode bits stand until the next write, the level bits are left as they are
    task automatic write_cfg(input logic so, input logic de, input logic off, input logic ac);
        @(posedge clk);
        #1;
        cmdWrite = 1'b1;
        {standbyOut, diagEnable, offset_test_enable_bit, ac_test_enable_bit} = {so, de, off, ac};
        @(posedge clk);
        #1;
        cmdWrite = 1'b0;
    endtask : write_cfg
    // change the level bits only; they take effect at the next write
    task automatic set_levels(input logic [2:0] lv);
        @(posedge clk);
        #1;
        {ac_threshold_select_bit, voltage_gain_setting, lineDriverDiag} = lv;
    endtask : set_levels
    // one read strobe; a full cycle passes before any re-entry
    task automatic read_diag();
        @(posedge clk);
        #1;
        hostRead = 1'b1;
        @(posedge clk);
        #1;
        hostRead = 1'b0;
    endtask : read_diag
endmodule : sods_host_model
`default_nettype wire

// *** verification/sods_sequencer_bench.sv ***
// self-checking bench for the diagnostic sequencer, shortened counts
// assumes the host partner model; comparator inputs are driven here
`default_nettype none
module sods_sequencer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [15:0] f, fm; logic [3:0] o, om, t, tm;} sods_note_t;
    logic clk, reset, cmdWrite, standbyOut, diagEnable, hostRead; // control
    logic offEn, acEn, acThr, gain, lineDrv; // instruction bits
    logic [3:0] shortGndIn, shortVsIn, loadShortIn, openLoadIn; // comparators
    logic [3:0] overloadIn, offsetHighIn, acPulseIn; // protection, offset, ac
    logic [15:0] faultRpt_r; // fault nibbles
    logic [3:0] offsetRpt_r, tweeterOpenRpt_r, stageOn_r; // flags
    logic outputsHighZ_r, highZBands_r, acThrLow_r; // stage state
    int n_fail = 0; // mismatches
    int check_count = 0; // comparisons
    int seed = 32'he1003d2e; // fixed seed
    int acCnt [4]; // ac pulses per channel
    logic [3:0] twExp; // expected open tweeters
    sods_note_t notes [$]; // expected read results, oldest first
    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    sods_sequencer #(.NCH(4), .PULSE_CYC(20), .DIAG_CYC(20), .CHECK_CYC(5)) i_sods_sequencer (
        .clk(clk), .reset(reset), .cmdWrite(cmdWrite), .standbyOut(standbyOut),
        .diagEnable(diagEnable), .offset_test_enable_bit(offEn), .ac_test_enable_bit(acEn),
        .ac_threshold_select_bit(acThr), .voltage_gain_setting(gain),
        .lineDriverDiag(lineDrv), .hostRead(hostRead), .shortGndIn(shortGndIn),
        .shortVsIn(shortVsIn), .loadShortIn(loadShortIn), .openLoadIn(openLoadIn),
        .overloadIn(overloadIn), .offsetHighIn(offsetHighIn), .acPulseIn(acPulseIn),
        .faultRpt_r(faultRpt_r), .offsetRpt_r(offsetRpt_r),
        .tweeterOpenRpt_r(tweeterOpenRpt_r), .stageOn_r(stageOn_r),
        .outputsHighZ_r(outputsHighZ_r), .highZBands_r(highZBands_r), .acThrLow_r(acThrLow_r));
    sods_host_model i_sods_host_model (
        .clk(clk), .cmdWrite(cmdWrite), .standbyOut(standbyOut), .diagEnable(diagEnable),
        .offset_test_enable_bit(offEn), .ac_test_enable_bit(acEn),
        .ac_threshold_select_bit(acThr), .voltage_gain_setting(gain),
        .lineDriverDiag(lineDrv), .hostRead(hostRead));
    // masked compare; an unknown bit under the mask never matches
    task automatic chk(input string nm, input logic [15:0] exp, got, msk);
        check_count++;
        if ((got & msk) !== (exp & msk))
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp & msk, got & msk);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    // step n edges, land just after the last one
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // bounded wait for {outputsHighZ_r, stageOn_r}; a timeout ends the run
    task automatic wait_out(input logic [4:0] want, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            if ({outputsHighZ_r, stageOn_r} === want)
                return;
            tick(1);
        end
        n_fail++;
        $display("ERROR wait_out expected %h seen %h", want, {outputsHighZ_r, stageOn_r});
        print_verdict();
    endtask : wait_out
    // watcher: results land one edge after the read strobe
    always @(posedge clk)
    begin
        sods_note_t nt;
        if (hostRead === 1'b1)
        begin
            @(posedge clk);
            #2;
            nt = notes.pop_front();
            chk("faultRpt", nt.f, faultRpt_r, nt.fm);
            chk("offsetRpt", 16'(nt.o), 16'(offsetRpt_r), 16'(nt.om));
            chk("tweeterOpen", 16'(nt.t), 16'(tweeterOpenRpt_r), 16'(nt.tm));
        end
    end
    initial
    begin
        reset = 1'b1;
        {shortGndIn, shortVsIn, loadShortIn, openLoadIn} = 16'h0000;
        {overloadIn, offsetHighIn, acPulseIn} = 12'h000;
        tick(6);
        reset = 1'b0;
        chk("highZ stage", 16'h0010, 16'({outputsHighZ_r, stageOn_r}), 16'h001F);
        // turn-on: gnd+vs on ch0, open ch1, short with open speaker on ch3
        shortGndIn = 4'h1;
        shortVsIn = 4'h1;
        openLoadIn = 4'hA;
        loadShortIn = 4'h8;
        i_sods_host_model.write_cfg(1'b1, 1'b1, 1'b0, 1'b0);
        chk("pulse highZ", 16'h0010, 16'({outputsHighZ_r, stageOn_r}), 16'h001F);
        wait_out(5'h0F, 60);
        chk("bands thr", 16'h0003, 16'({highZBands_r, acThrLow_r}), 16'h0003);
        {shortGndIn, shortVsIn, loadShortIn, openLoadIn} = 16'h0000;
        notes.push_back('{16'h201C, 16'hFFFF, 4'h0, 4'hF, 4'h0, 4'hF});
        i_sods_host_model.read_diag();
        $display("test turn_on done");
        // offset window and ac pulse count, random count per channel
        offsetHighIn = 4'h3;
        tick(3);
        i_sods_host_model.write_cfg(1'b1, 1'b1, 1'b1, 1'b1);
        for (int c = 0; c < 4; c++)
        begin
            acCnt[c] = ($random(seed) & 7) % 6;
            twExp[c] = (acCnt[c] < 3);
        end
        // tone lasts well over three pulse periods before the read
        for (int p = 0; p < 6; p++)
        begin
            for (int c = 0; c < 4; c++)
                acPulseIn[c] = (acCnt[c] > p);
            offsetHighIn[1] = (p != 2);
            tick(3);
            acPulseIn = 4'h0;
            tick(3);
        end
        notes.push_back('{16'h201C, 16'hFFFF, 4'h1, 4'hF, twExp, 4'hF});
        i_sods_host_model.read_diag();
        $display("test offset_ac done");
        // brief overload: channel drops, recheck finds it clear
        tick(3);
        overloadIn = 4'h8;
        tick(1);
        overloadIn = 4'h0;
        wait_out(5'h07, 10);
        wait_out(5'h0F, 30);
        $display("test glitch done");
        // lasting overload with vs short and open load on ch2
        shortVsIn = 4'h4;
        openLoadIn = 4'h4;
        overloadIn = 4'h4;
        wait_out(5'h0B, 10);
        tick(60);
        chk("restart stage", 16'h000B, 16'(stageOn_r), 16'h000F);
        // ch0/ch1 keep high offset and saw no tone since the last read
        notes.push_back('{16'h241C, 16'hFFFF, 4'h3, 4'hF, 4'h3, 4'hF});
        i_sods_host_model.read_diag();
        overloadIn = 4'h0;
        {shortVsIn, openLoadIn} = 8'h00;
        wait_out(5'h0F, 20);
        // normal bands and high ac level: gain low but no line-driver diagnostic
        i_sods_host_model.set_levels(3'h2);
        i_sods_host_model.write_cfg(1'b1, 1'b1, 1'b0, 1'b0);
        chk("bands thr", 16'h0000, 16'({highZBands_r, acThrLow_r}), 16'h0003);
        $display("test permanent done");
        tick(3);
        print_verdict();
    end
endmodule : sods_sequencer_bench
`default_nettype wire
